//--- common/ppsrw_pkg.sv
// constants, types and address functions for the paged program-space read window
package ppsrw_pkg;

  // ------------------------------------------------------------------
  // widths
  // ------------------------------------------------------------------
  localparam int EA_W      = 16;
  localparam int PAGE_W    = 10;
  localparam int PS_ADDR_W = 24;
  localparam int WIN_W     = 15;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int PAGE_PSV_BIT = 9;
  localparam int EA_WIN_BIT   = 15;

  // ------------------------------------------------------------------
  // values and sizes
  // ------------------------------------------------------------------
  localparam logic [PAGE_W-1:0]    PSV_PAGE_MIN   = 10'h200;
  localparam logic [PAGE_W-1:0]    PAGE_RST       = 10'h001;
  localparam int                   WINDOW_BYTES   = 32768;
  localparam int                   PSV_SPAN_BYTES = 8388608;
  localparam logic [PS_ADDR_W-1:0] PS_ADDR_TOP    = 24'hFFFFFF;
  localparam logic [EA_W-1:0]      EA_RST         = 16'h0000;
  localparam logic [PS_ADDR_W-1:0] PS_ADDR_RST    = 24'h000000;

  // ------------------------------------------------------------------
  // address modification modes
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    PPSRW_MODE_NONE,
    PPSRW_MODE_PRE,
    PPSRW_MODE_POST
  } ppsrw_mode_t;

  // ------------------------------------------------------------------
  // functions
  // ------------------------------------------------------------------
  function automatic logic ppsrw_is_paged(input logic [PAGE_W-1:0] page,
                                          input logic [EA_W-1:0]   ea);
    return page[PAGE_PSV_BIT] & ea[EA_WIN_BIT];
  endfunction

  function automatic logic [PS_ADDR_W-1:0] ppsrw_ps_addr(input logic [PAGE_W-1:0] page,
                                                         input logic [EA_W-1:0]   ea);
    return {page[PAGE_PSV_BIT-1:0], ea[WIN_W-1:0]};
  endfunction

endpackage

//--- hdl/ppsrw_xlate.sv
// effective address modification and program-space translation
module ppsrw_xlate
  import ppsrw_pkg::*;
(
  input  wire logic [PAGE_W-1:0]    page,
  input  wire logic [EA_W-1:0]      ea,
  input  wire logic [EA_W-1:0]      offset,
  input  wire ppsrw_mode_t          mode,
  output logic      [EA_W-1:0]      ea_eff,
  output logic      [EA_W-1:0]      ptr_next,
  output logic                      paged,
  output logic      [PS_ADDR_W-1:0] ps_addr
);

  logic [EA_W-1:0] ea_sum;

  // ------------------------------------------------------------------
  // pre/post modification
  // ------------------------------------------------------------------
  always_comb begin
    // wraps in 16 bits like the pointer register itself
    ea_sum   = ea + offset;
    ea_eff   = ea;
    ptr_next = ea;
    case (mode)
      PPSRW_MODE_PRE: begin
        ea_eff   = ea_sum;
        ptr_next = ea_sum;
      end
      PPSRW_MODE_POST: begin
        ea_eff   = ea;
        ptr_next = ea_sum;
      end
      default: begin
        ea_eff   = ea;
        ptr_next = ea;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // translation
  // ------------------------------------------------------------------
  always_comb begin
    paged   = ppsrw_is_paged(page, ea_eff);
    ps_addr = ppsrw_ps_addr(page, ea_eff);
  end

endmodule // ppsrw_xlate

//--- hdl/ppsrw_top.sv
// paged program-space read window: page holding, routing and checks
// Overview of operation
// - with page bit 9 and address bit 15 both set, page bits 8..0 sit above address bits 14..0 to make a 24-bit read address.
// - only the upper half of the data address range, with the page, yields a program-space address.
// - each page value of 0x200 or more picks one 32-Kbyte window and the next page value the next window.
// - page and upper address together reach a visible program space of up to 16 Mbytes.
// - program space is reached only with a page of 0x200 or more, which software loads beforehand.
// - the paged path only reads program space and never writes it.
// - plain moves reach the paged space linearly, also with pre- or post-modified addresses.
module ppsrw_top
  import ppsrw_pkg::*;
(
  input  wire logic                     SYS_CLK,
  input  wire logic                     RSTN,
  input  wire logic                     PAGE_WE,
  input  wire logic [PAGE_W-1:0]        PAGE_WDATA,
  output logic      [PAGE_W-1:0]        PAGE_Q,
  input  wire logic                     REQ_VALID,
  input  wire logic                     REQ_WRITE,
  input  wire ppsrw_pkg::ppsrw_mode_t   REQ_MODE,
  input  wire logic [EA_W-1:0]          REQ_EA,
  input  wire logic [EA_W-1:0]          REQ_OFFSET,
  input  wire logic [EA_W-1:0]          REQ_WDATA,
  output logic      [EA_W-1:0]          PTR_NEXT,
  output logic                          PS_RD_EN,
  output logic      [PS_ADDR_W-1:0]     PS_RD_ADDR,
  output logic                          DS_EN,
  output logic                          DS_WE,
  output logic      [EA_W-1:0]          DS_ADDR,
  output logic      [EA_W-1:0]          DS_WDATA,
  output logic                          WR_REJECT
);

  import ppsrw_pkg::*;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic [PAGE_W-1:0]    page_q,    page_d;
  logic [EA_W-1:0]      ptr_q,     ptr_d;
  logic                 ps_en_q,   ps_en_d;
  logic [PS_ADDR_W-1:0] ps_addr_q, ps_addr_d;
  logic                 ds_en_q,   ds_en_d;
  logic                 ds_we_q,   ds_we_d;
  logic [EA_W-1:0]      ds_addr_q, ds_addr_d;
  logic [EA_W-1:0]      ds_wd_q,   ds_wd_d;
  logic                 rej_q,     rej_d;

  logic [EA_W-1:0]      ea_eff;
  logic [EA_W-1:0]      ptr_next;
  logic                 paged;
  logic [PS_ADDR_W-1:0] ps_addr;

  // ------------------------------------------------------------------
  // translation
  // ------------------------------------------------------------------
  ppsrw_xlate u_xlate (
    .page     (page_q),
    .ea       (REQ_EA),
    .offset   (REQ_OFFSET),
    .mode     (REQ_MODE),
    .ea_eff   (ea_eff),
    .ptr_next (ptr_next),
    .paged    (paged),
    .ps_addr  (ps_addr)
  );

  // ------------------------------------------------------------------
  // page holding
  // ------------------------------------------------------------------
  // a request in the same cycle as a page load still sees the old page
  always_comb begin
    page_d = page_q;
    if (PAGE_WE) begin
      page_d = PAGE_WDATA;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      page_q <= PAGE_RST;
    end else begin
      page_q <= page_d;
    end
  end

  // ------------------------------------------------------------------
  // access routing
  // ------------------------------------------------------------------
  always_comb begin
    ptr_d     = ptr_q;
    ps_en_d   = 1'b0;
    ps_addr_d = ps_addr_q;
    ds_en_d   = 1'b0;
    ds_we_d   = 1'b0;
    ds_addr_d = ds_addr_q;
    ds_wd_d   = ds_wd_q;
    rej_d     = 1'b0;
    if (REQ_VALID) begin
      ptr_d = ptr_next;
      if (paged && REQ_WRITE) begin
        // no write port into program space exists; drop and flag
        rej_d = 1'b1;
      end else if (paged) begin
        ps_en_d   = 1'b1;
        ps_addr_d = ps_addr;
      end else begin
        ds_en_d   = 1'b1;
        ds_we_d   = REQ_WRITE;
        ds_addr_d = ea_eff;
        ds_wd_d   = REQ_WDATA;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ptr_q     <= EA_RST;
      ps_en_q   <= 1'b0;
      ps_addr_q <= PS_ADDR_RST;
      ds_en_q   <= 1'b0;
      ds_we_q   <= 1'b0;
      ds_addr_q <= EA_RST;
      ds_wd_q   <= EA_RST;
      rej_q     <= 1'b0;
    end else begin
      ptr_q     <= ptr_d;
      ps_en_q   <= ps_en_d;
      ps_addr_q <= ps_addr_d;
      ds_en_q   <= ds_en_d;
      ds_we_q   <= ds_we_d;
      ds_addr_q <= ds_addr_d;
      ds_wd_q   <= ds_wd_d;
      rej_q     <= rej_d;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign PAGE_Q     = page_q;
  assign PTR_NEXT   = ptr_q;
  assign PS_RD_EN   = ps_en_q;
  assign PS_RD_ADDR = ps_addr_q;
  assign DS_EN      = ds_en_q;
  assign DS_WE      = ds_we_q;
  assign DS_ADDR    = ds_addr_q;
  assign DS_WDATA   = ds_wd_q;
  assign WR_REJECT  = rej_q;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  a_psv_addr_form: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    (REQ_VALID && !REQ_WRITE && page_q[PAGE_PSV_BIT] && ea_eff[EA_WIN_BIT])
    |=> PS_RD_EN && PS_RD_ADDR == {$past(page_q[8:0]), $past(ea_eff[14:0])})
    else $error("paged read address not formed from page and address");

  a_upper_half_only: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    PS_RD_EN |-> $past(ea_eff[EA_WIN_BIT]) && $past(REQ_VALID))
    else $error("program read from lower half of data space");

  a_window_step: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    (PS_RD_EN && $past(PS_RD_EN) && $past(page_q) == $past(page_q, 2) + 10'h001
     && $past(ea_eff) == $past(ea_eff, 2))
    |-> PS_RD_ADDR - $past(PS_RD_ADDR) == 24'h008000)
    else $error("next page did not select next 32K window");

  a_span_top: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    (REQ_VALID && !REQ_WRITE && page_q == 10'h3FF && ea_eff == 16'hFFFF)
    |=> PS_RD_EN && PS_RD_ADDR == PS_ADDR_TOP)
    else $error("top of visible program space not reached");

  a_page_min: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    PS_RD_EN |-> $past(page_q) >= PSV_PAGE_MIN)
    else $error("program space reached with page below minimum");

  a_no_ps_write: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    (REQ_VALID && REQ_WRITE && paged) |=> WR_REJECT && !PS_RD_EN && !DS_EN && !DS_WE)
    else $error("write through paged window not refused");

  a_post_modify: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    (REQ_VALID && REQ_MODE == PPSRW_MODE_POST)
    |=> PTR_NEXT == $past(REQ_EA) + $past(REQ_OFFSET)
        && (PS_RD_EN || DS_EN || WR_REJECT)
        && (!DS_EN || DS_ADDR == $past(REQ_EA)))
    else $error("post-modified access used wrong address");

  a_pre_modify: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    (REQ_VALID && REQ_MODE == PPSRW_MODE_PRE && !paged)
    |=> DS_EN && DS_ADDR == $past(REQ_EA) + $past(REQ_OFFSET))
    else $error("pre-modified access used wrong address");

  a_plain_data: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    (REQ_VALID && !(page_q[PAGE_PSV_BIT] && ea_eff[EA_WIN_BIT]))
    |=> DS_EN && !PS_RD_EN && !WR_REJECT && DS_ADDR == $past(ea_eff)
        && DS_WE == $past(REQ_WRITE))
    else $error("unpaged access not routed to data space");

  a_idle_quiet: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN)
    !REQ_VALID |=> !PS_RD_EN && !DS_EN && !WR_REJECT)
    else $error("strobe without request");

endmodule // ppsrw_top

//--- verif/ppsrw_pmem.sv
// program memory read port model for the paged window
module ppsrw_pmem
  import ppsrw_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 rd_en,
  input  wire logic [PS_ADDR_W-1:0] rd_addr,
  output int                        n_rd,
  output logic      [PS_ADDR_W-1:0] last_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------------
  // read port
  // ------------------------------------------------------------------
  // read strobe only: nothing here can be written
  // full 24-bit address taken, no folding
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      n_rd <= 0;
      last_addr <= 24'h000000;
    end else if (rd_en) begin
      n_rd <= n_rd + 1;
      last_addr <= rd_addr;
    end
  end
endmodule // ppsrw_pmem

//--- verif/paged_program_space_read_window_test.sv
// self-checking bench for the paged program-space read window
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module paged_program_space_read_window_test;
  timeunit 1ns;
  timeprecision 100ps;
  import ppsrw_pkg::*;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic SYS_CLK = 0, RSTN = 0, PAGE_WE = 0, REQ_VALID = 0, REQ_WRITE = 0;
  logic [PAGE_W-1:0] PAGE_WDATA = 10'h000, PAGE_Q;
  ppsrw_mode_t REQ_MODE = PPSRW_MODE_NONE;
  logic [EA_W-1:0] REQ_EA = 16'h0000, REQ_OFFSET = 16'h0000, REQ_WDATA = 16'h0000;
  logic [EA_W-1:0] PTR_NEXT, DS_ADDR, DS_WDATA;
  logic PS_RD_EN, DS_EN, DS_WE, WR_REJECT;
  logic [PS_ADDR_W-1:0] PS_RD_ADDR, pm_last;
  int pm_n, n_mismatch = 0, samples_checked = 0;
  always #2 SYS_CLK = ~SYS_CLK;
  ppsrw_top uut (.*);
  ppsrw_pmem pmem (.clk(SYS_CLK), .rst_n(RSTN), .rd_en(PS_RD_EN), .rd_addr(PS_RD_ADDR),
                   .n_rd(pm_n), .last_addr(pm_last));
  // ------------------------------------------------------------------
  // drivers
  // ------------------------------------------------------------------
  task automatic ld(input logic [PAGE_W-1:0] v);
    @(posedge SYS_CLK) #1 PAGE_WE = 1;
    PAGE_WDATA = v;
    @(posedge SYS_CLK) #1 PAGE_WE = 0;
    `CHK("page", v, PAGE_Q)
  endtask
  // kind: 0 program read, 1 data read, 2 data write, 3 dropped write
  task automatic rq(input logic w, input ppsrw_mode_t m, input logic [15:0] ea, off,
                    input int k, input logic [23:0] a);
    @(posedge SYS_CLK) #1 REQ_VALID = 1;
    REQ_WRITE = w;
    REQ_MODE = m;
    REQ_EA = ea;
    REQ_OFFSET = off;
    REQ_WDATA = ~ea;
    @(posedge SYS_CLK) #1 REQ_VALID = 0;
    chk(k, a, ~ea);
  endtask
  task automatic chk(input int k, input logic [23:0] a, input logic [15:0] wd);
    `CHK("rd_en", k == 0, PS_RD_EN)
    `CHK("ds_en", k == 1 || k == 2, DS_EN)
    `CHK("ds_we", k == 2, DS_WE)
    `CHK("reject", k == 3, WR_REJECT)
    if (k == 0) `CHK("ps_addr", a, PS_RD_ADDR)
    if (k == 1 || k == 2) `CHK("ds_addr", a[15:0], DS_ADDR)
    if (k == 2) `CHK("ds_wdata", wd, DS_WDATA)
  endtask
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    `CHK("page_rst", PAGE_RST, PAGE_Q)
    chk(-1, 24'h000000, 16'h0000);
  endtask
  task automatic t_post_pre;
    ld(10'h201);
    rq(0, PPSRW_MODE_POST, 16'h8004, 16'h0002, 0, 24'h008004);
    `CHK("ptr_post", 16'h8006, PTR_NEXT)
    ld(10'h3FF);
    rq(0, PPSRW_MODE_PRE, 16'hFFF0, 16'h000E, 0, 24'hFFFFFE);
    `CHK("ptr_pre", 16'hFFFE, PTR_NEXT)
  endtask
  task automatic t_windows;
    ld(10'h200);
    rq(0, PPSRW_MODE_NONE, 16'h8000, 16'h0000, 0, 24'h000000);
    rq(0, PPSRW_MODE_NONE, 16'hFFFF, 16'h0000, 0, 24'h007FFF);
    ld(10'h201);
    rq(0, PPSRW_MODE_NONE, 16'h8000, 16'h0000, 0, 24'h008000);
  endtask
  task automatic t_data;
    rq(0, PPSRW_MODE_NONE, 16'h7FFF, 16'h0000, 1, 24'h007FFF);
    rq(1, PPSRW_MODE_PRE, 16'h7FFE, 16'h0004, 3, 24'h000000);
    ld(10'h1FF);
    rq(0, PPSRW_MODE_NONE, 16'h8000, 16'h0000, 1, 24'h008000);
    rq(1, PPSRW_MODE_NONE, 16'h9000, 16'h0000, 2, 24'h009000);
  endtask
  task automatic t_reject_old_page;
    int n0;
    ld(10'h201);
    n0 = pm_n;
    rq(1, PPSRW_MODE_NONE, 16'h9000, 16'h0000, 3, 24'h000000);
    `CHK("no_read", n0, pm_n)
    // page load and request together: request still sees the old page
    @(posedge SYS_CLK) #1 PAGE_WE = 1;
    PAGE_WDATA = 10'h005;
    REQ_VALID = 1;
    REQ_WRITE = 0;
    REQ_EA = 16'h8010;
    @(posedge SYS_CLK) #1 PAGE_WE = 0;
    REQ_VALID = 0;
    chk(0, 24'h008010, 16'h0000);
    // the memory model takes the strobe one edge after it rises
    @(posedge SYS_CLK) #1;
    `CHK("pm_addr", 24'h008010, pm_last)
  endtask
  // ------------------------------------------------------------------
  // sequence and verdict
  // ------------------------------------------------------------------
  task automatic end_of_test;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge SYS_CLK);
    #1 RSTN = 1;
    t_reset();
    t_post_pre();
    t_windows();
    t_data();
    t_reject_old_page();
    end_of_test();
  end
  // about 40 cycles expected, so this is generous
  initial begin
    #20000;
    n_mismatch++;
    end_of_test();
  end
endmodule // paged_program_space_read_window_test
